// ---- src/fpmc_fan_mode.sv ----
// fan mode control: software duty, thermal trip, automatic loop, event latches and pwm outputs
`timescale 1ns/100ps
module fpmc_fan_mode
	import fpmc_pkg::*;
#(
	parameter int SPINUP_LEN = SPINUP_CYCLES
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	output logic                  wb_err_o,
	input  wire logic [23:0]      temp_i,
	input  wire logic [1:0]       fan_present_i,
	input  wire logic [1:0]       fan_fault_n_i,
	input  wire logic [1:0]       tach_fail_i,
	input  wire logic [1:0]       hotplug_req_i,
	output logic      [1:0]       pwm_o,
	output logic      [1:0]       pwm_oe,
	output logic                  int_n_o
);
	typedef struct packed {
		logic [2:0][7:0] fault_act;
		logic [2:0][7:0] cool;
		logic [1:0][7:0] duty;
		logic [2:0][7:0] range;
		logic [2:0][7:0] high;
		logic [2:0][7:0] turn_on;
		logic [1:0][7:0] status;
		logic [2:0]      running;
		logic [2:0]      trip;
		logic [1:0]      present_q;
		logic [1:0][31:0] spin;
		logic [1:0]      on_q;
		logic [3:0]      pwm_cnt;
		logic [1:0]      pwm;
		logic [1:0]      pwm_en;
		logic [31:0]     dat;
		logic            ack;
		logic            err;
		logic            irq_n;
	} fpmc_state_t;

	fpmc_state_t state_reg;
	fpmc_state_t state_next;

	// two-flop synchronisers on the fan pins
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	always_ff @(posedge clock) begin
		if (rst) begin
			// idle pin levels, so release of reset shows no false tach or hot-plug event
			sync1_reg <= SYNC_IDLE;
			sync2_reg <= SYNC_IDLE;
		end else begin
			sync1_reg <= {hotplug_req_i, tach_fail_i, fan_fault_n_i, fan_present_i};
			sync2_reg <= sync1_reg;
		end
	end
	logic [1:0] present_s;
	logic [1:0] fault_n_s;
	logic [1:0] tach_s;
	logic [1:0] hp_req_s;
	assign present_s = sync2_reg[1:0];
	assign fault_n_s = sync2_reg[3:2];
	assign tach_s    = sync2_reg[5:4];
	assign hp_req_s  = sync2_reg[7:6];

	// per-channel turn-on, turn-off margin and trip detection
	logic [2:0]      over_lim;
	logic [2:0]      above_on;
	logic [2:0]      below_off;
	genvar gc;
	generate
		for (gc = 0; gc < NCH; gc++) begin : g_ch
			logic [7:0] t;
			logic [8:0] off_pt;
			assign t         = temp_i[gc*8 +: 8];
			assign over_lim[gc]  = t > state_reg.high[gc];
			assign above_on[gc]  = t > state_reg.turn_on[gc];
			assign off_pt        = {1'b0, state_reg.turn_on[gc]} - {5'h00, state_reg.range[gc][7:4]};
			assign below_off[gc] = off_pt[8] ? 1'b0 : ({1'b0, t} < off_pt);
		end
	endgenerate

	// linear duty: min + (15-min)*(t-turn_on)/span, clipped at full
	function automatic logic [3:0] fpmc_slope(input logic [7:0] t, input logic [7:0] on_t,
			input logic [3:0] span, input logic [3:0] dmin);
		logic [7:0]  dt;
		logic [11:0] inc;
		logic [7:0]  sp;
		logic [11:0] sum;
		dt  = (t > on_t) ? 8'(t - on_t) : 8'h00;
		sp  = (span == 4'h0) ? 8'h01 : {4'h0, span};
		inc = 12'(({4'h0, dt} * {8'h00, 4'(DUTY_FULL - dmin)}) / {4'h0, sp});
		sum = inc + {8'h00, dmin};
		fpmc_slope = (sum >= {8'h00, DUTY_FULL}) ? DUTY_FULL : sum[3:0];
	endfunction : fpmc_slope

	logic       sw_mode;
	logic [1:0] alarm_f;
	logic [1:0] hp_f;
	logic [1:0][3:0] auto_duty;
	logic [1:0] auto_on;
	logic [1:0][3:0] sel_duty;
	always_comb begin
		sw_mode = (state_reg.cool[0][1:0] == 2'b00) && (state_reg.cool[1][1:0] == 2'b00)
			&& (state_reg.cool[2][1:0] == 2'b00);
		for (int f = 0; f < NFAN; f++) begin
			alarm_f[f]   = 1'b0;
			auto_duty[f] = 4'h0;
			auto_on[f]   = 1'b0;
			for (int c = 0; c < NCH; c++) begin
				if (state_reg.cool[c][f]) begin
					alarm_f[f] = alarm_f[f] | state_reg.trip[c];
					if (state_reg.running[c]) begin
						auto_on[f] = 1'b1;
						// fastest channel wins when several drive one fan
						if (fpmc_slope(temp_i[c*8 +: 8], state_reg.turn_on[c], state_reg.range[c][3:0],
								state_reg.duty[f][3:0]) > auto_duty[f])
							auto_duty[f] = fpmc_slope(temp_i[c*8 +: 8], state_reg.turn_on[c],
								state_reg.range[c][3:0], state_reg.duty[f][3:0]);
					end
				end
			end
			hp_f[f] = hp_req_s[f] | (present_s != 2'b11 && present_s[f]);
			if (alarm_f[f] && !(hp_f[f] && state_reg.status[f][BIT_HOTPLUG_PRIO]))
				sel_duty[f] = state_reg.duty[f][7:4];
			else if (hp_f[f])
				sel_duty[f] = DUTY_FULL;
			else if (sw_mode)
				sel_duty[f] = state_reg.duty[f][3:0];
			else if (!auto_on[f])
				sel_duty[f] = 4'h0;
			else if (state_reg.spin[f] != 32'h0)
				sel_duty[f] = DUTY_FULL;
			else
				sel_duty[f] = auto_duty[f];
		end
	end

	logic hit;
	logic [7:0] a;
	always_comb begin
		state_next = state_reg;
		a          = wb_adr_i;
		hit        = wb_cyc_i && wb_stb_i && !state_reg.ack && !state_reg.err;
		state_next.ack = 1'b0;
		state_next.err = 1'b0;
		// pwm counter runs 0..14, so code 15 stays high all period
		state_next.pwm_cnt = (state_reg.pwm_cnt == 4'hE) ? 4'h0 : 4'(state_reg.pwm_cnt + 4'h1);
		for (int f = 0; f < NFAN; f++) begin
			state_next.pwm[f]    = sel_duty[f] > state_reg.pwm_cnt;
			// open drain: enable only in the low phase, the pull-up gives the high phase
			state_next.pwm_en[f] = sel_duty[f] <= state_reg.pwm_cnt;
		end
		for (int c = 0; c < NCH; c++) begin
			if (!state_reg.running[c] && above_on[c])
				state_next.running[c] = 1'b1;
			else if (state_reg.running[c] && below_off[c])
				state_next.running[c] = 1'b0;
		end
		for (int f = 0; f < NFAN; f++) begin
			state_next.on_q[f] = auto_on[f];
			if (auto_on[f] && !state_reg.on_q[f])
				state_next.spin[f] = 32'(SPINUP_LEN);
			else if (state_reg.spin[f] != 32'h0)
				state_next.spin[f] = state_reg.spin[f] - 32'h1;
		end
		state_next.present_q = present_s;
		// register access first, so hardware events below override a same-cycle clear
		if (hit) begin
			state_next.ack = 1'b1;
			state_next.dat = 32'h0;
			case (a)
				OFS_LOCAL_FAULT_ACT, OFS_REMOTE1_FAULT_ACT, OFS_REMOTE2_FAULT_ACT: begin
					state_next.dat[7:0] = state_reg.fault_act[a - OFS_LOCAL_FAULT_ACT];
					if (wb_we_i && wb_sel_i[0])
						state_next.fault_act[a - OFS_LOCAL_FAULT_ACT] = wb_dat_i[7:0];
				end
				OFS_LOCAL_COOL, OFS_REMOTE1_COOL, OFS_REMOTE2_COOL: begin
					state_next.dat[7:0] = state_reg.cool[a - OFS_LOCAL_COOL];
					if (wb_we_i && wb_sel_i[0])
						state_next.cool[a - OFS_LOCAL_COOL] = wb_dat_i[7:0];
				end
				OFS_FAN1_DUTY, OFS_FAN2_DUTY: begin
					state_next.dat[7:0] = state_reg.duty[a - OFS_FAN1_DUTY];
					if (wb_we_i && wb_sel_i[0])
						state_next.duty[a - OFS_FAN1_DUTY] = wb_dat_i[7:0];
				end
				OFS_LOCAL_RANGE, OFS_REMOTE1_RANGE, OFS_REMOTE2_RANGE: begin
					state_next.dat[7:0] = state_reg.range[a - OFS_LOCAL_RANGE];
					if (wb_we_i && wb_sel_i[0])
						state_next.range[a - OFS_LOCAL_RANGE] = wb_dat_i[7:0];
				end
				OFS_LOCAL_HIGH, OFS_REMOTE1_HIGH, OFS_REMOTE2_HIGH: begin
					state_next.dat[7:0] = state_reg.high[a - OFS_LOCAL_HIGH];
					if (wb_we_i && wb_sel_i[0])
						state_next.high[a - OFS_LOCAL_HIGH] = wb_dat_i[7:0];
				end
				OFS_LOCAL_TURN_ON, OFS_REMOTE1_TURN_ON, OFS_REMOTE2_TURN_ON: begin
					state_next.dat[7:0] = state_reg.turn_on[a - OFS_LOCAL_TURN_ON];
					if (wb_we_i && wb_sel_i[0])
						state_next.turn_on[a - OFS_LOCAL_TURN_ON] = wb_dat_i[7:0];
				end
				OFS_FAN1_STATUS, OFS_FAN2_STATUS: begin
					state_next.dat[7:0] = state_reg.status[a - OFS_FAN1_STATUS];
					if (wb_we_i && wb_sel_i[0])
						state_next.status[a - OFS_FAN1_STATUS] = wb_dat_i[7:0];
				end
				OFS_FAN_OUT_STATE: begin
					state_next.dat[7:0] = {1'b0, state_reg.running, state_reg.trip[1:0], state_reg.pwm};
				end
				default: begin
					state_next.ack = 1'b0;
					state_next.err = 1'b1;
				end
			endcase
		end
		for (int c = 0; c < NCH; c++) begin
			if (state_reg.fault_act[c][BIT_ALARM_EN] && over_lim[c] && (state_reg.cool[c][1:0] != 2'b00)) begin
				state_next.trip[c] = 1'b1;
				// latch follows the hot condition, not the held trip, or a clear could never stick
				state_next.fault_act[c][BIT_TEMP_LATCH] = 1'b1;
			end else if (!over_lim[c] && !state_reg.fault_act[c][BIT_TEMP_LATCH]) begin
				state_next.trip[c] = 1'b0;
			end
		end
		for (int f = 0; f < NFAN; f++) begin
			if (state_reg.present_q[f] && !present_s[f])
				state_next.status[f][BIT_MISSING] = 1'b1;
			if (!state_reg.present_q[f] && present_s[f])
				state_next.status[f][BIT_HOTPLUG] = 1'b1;
			if (!fault_n_s[f])
				state_next.status[f][BIT_FAULT] = 1'b1;
			if (tach_s[f])
				state_next.status[f][BIT_TACH] = 1'b1;
		end
		state_next.irq_n = !(|(state_reg.status[0] & STATUS_LATCH) || |(state_reg.status[1] & STATUS_LATCH)
			|| state_reg.fault_act[0][BIT_TEMP_LATCH] || state_reg.fault_act[1][BIT_TEMP_LATCH]
			|| state_reg.fault_act[2][BIT_TEMP_LATCH]);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg         <= '0;
			state_reg.duty    <= {RST_DUTY, RST_DUTY};
			state_reg.cool    <= {RST_COOL, RST_COOL, RST_COOL};
			state_reg.range   <= {RST_RANGE, RST_RANGE, RST_RANGE};
			state_reg.high    <= {RST_HIGH, RST_HIGH, RST_HIGH};
			state_reg.turn_on <= {RST_TURN_ON, RST_TURN_ON, RST_TURN_ON};
			state_reg.present_q <= 2'b11;
			state_reg.pwm_en  <= '1;
			state_reg.irq_n   <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign wb_dat_o = state_reg.dat;
	assign wb_ack_o = state_reg.ack;
	assign wb_err_o = state_reg.err;
	assign pwm_o    = state_reg.pwm;
	assign pwm_oe   = state_reg.pwm_en;
	assign int_n_o  = state_reg.irq_n;

	// guards on latches, duty selection, trip and the bus answer
	a_irq_follows: assert property (@(posedge clock) disable iff (rst)
		(state_reg.status[0][BIT_FAULT]) |=> !int_n_o)
		else $error("interrupt not raised for latched fault");
	a_fault_latch: assert property (@(posedge clock) disable iff (rst)
		(!fault_n_s[0]) |=> state_reg.status[0][BIT_FAULT])
		else $error("fault latch not set");
	a_latch_holds: assert property (@(posedge clock) disable iff (rst)
		(state_reg.status[1][BIT_TACH] && !(hit && wb_we_i)) |=> state_reg.status[1][BIT_TACH])
		else $error("tach latch dropped without a write");
	a_full_duty: assert property (@(posedge clock) disable iff (rst)
		(sel_duty[0] == DUTY_FULL) [*2] |=> pwm_o[0])
		else $error("full duty not continuously high");
	a_zero_duty: assert property (@(posedge clock) disable iff (rst)
		(sel_duty[1] == 4'h0) |=> !pwm_o[1])
		else $error("zero duty drove pwm high");
	a_trip_hold: assert property (@(posedge clock) disable iff (rst)
		(state_reg.trip[2] && state_reg.fault_act[2][BIT_TEMP_LATCH]) |=> state_reg.trip[2])
		else $error("trip released while latch set");
	a_trip_latch: assert property (@(posedge clock) disable iff (rst)
		(state_reg.fault_act[2][BIT_ALARM_EN] && over_lim[2] && (state_reg.cool[2][1:0] != 2'b00))
		|=> (state_reg.trip[2] && state_reg.fault_act[2][BIT_TEMP_LATCH]))
		else $error("temp latch not set on trip");
	a_sw_duty: assert property (@(posedge clock) disable iff (rst)
		(sw_mode && !alarm_f[0] && !hp_f[0]) |-> sel_duty[0] == state_reg.duty[0][3:0])
		else $error("software duty not selected");
	a_bus_answer: assert property (@(posedge clock) disable iff (rst)
		(hit) |=> (wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o))
		else $error("bus answer not one cycle");
	a_trip_clear: assert property (@(posedge clock) disable iff (rst)
		(state_reg.trip[2] && !over_lim[2] && !state_reg.fault_act[2][BIT_TEMP_LATCH]) |=> !state_reg.trip[2])
		else $error("trip kept after cooling and clear");
	a_alarm_duty: assert property (@(posedge clock) disable iff (rst)
		(alarm_f[0] && !hp_f[0]) |-> (sel_duty[0] == state_reg.duty[0][7:4]))
		else $error("alarm duty not selected");
	a_missing_latch: assert property (@(posedge clock) disable iff (rst)
		(state_reg.present_q[0] && !present_s[0]) |=> state_reg.status[0][BIT_MISSING])
		else $error("missing latch not set");
	a_hotplug_latch: assert property (@(posedge clock) disable iff (rst)
		(!state_reg.present_q[0] && present_s[0]) |=> state_reg.status[0][BIT_HOTPLUG])
		else $error("hot-plug latch not set");
	a_tach_latch: assert property (@(posedge clock) disable iff (rst)
		tach_s[1] |=> state_reg.status[1][BIT_TACH])
		else $error("tach latch not set");
	a_spin_start: assert property (@(posedge clock) disable iff (rst)
		(auto_on[0] && !state_reg.on_q[0]) |=> (state_reg.spin[0] == 32'(SPINUP_LEN)))
		else $error("spin-up not started on turn-on");
	a_fan_stop: assert property (@(posedge clock) disable iff (rst)
		(state_reg.running[0] && below_off[0]) |=> !state_reg.running[0])
		else $error("fan kept running below margin");
endmodule : fpmc_fan_mode

// ---- src/fpmc_pkg.sv ----
// package: register map, field positions and timing constants of the fan mode block
package fpmc_pkg;
	localparam logic [7:0] OFS_LOCAL_FAULT_ACT   = 8'h40;
	localparam logic [7:0] OFS_REMOTE1_FAULT_ACT = 8'h41;
	localparam logic [7:0] OFS_REMOTE2_FAULT_ACT = 8'h42;
	localparam logic [7:0] OFS_LOCAL_COOL        = 8'h48;
	localparam logic [7:0] OFS_REMOTE1_COOL      = 8'h49;
	localparam logic [7:0] OFS_REMOTE2_COOL      = 8'h4A;
	localparam logic [7:0] OFS_FAN1_DUTY         = 8'h60;
	localparam logic [7:0] OFS_FAN2_DUTY         = 8'h61;
	localparam logic [7:0] OFS_LOCAL_RANGE       = 8'h88;
	localparam logic [7:0] OFS_REMOTE1_RANGE     = 8'h89;
	localparam logic [7:0] OFS_REMOTE2_RANGE     = 8'h8A;
	localparam logic [7:0] OFS_LOCAL_HIGH        = 8'h90;
	localparam logic [7:0] OFS_REMOTE1_HIGH      = 8'h91;
	localparam logic [7:0] OFS_REMOTE2_HIGH      = 8'h92;
	localparam logic [7:0] OFS_FAN1_STATUS       = 8'hA0;
	localparam logic [7:0] OFS_FAN2_STATUS       = 8'hA1;
	localparam logic [7:0] OFS_LOCAL_TURN_ON     = 8'hA4;
	localparam logic [7:0] OFS_REMOTE1_TURN_ON   = 8'hA5;
	localparam logic [7:0] OFS_REMOTE2_TURN_ON   = 8'hA6;
	localparam logic [7:0] OFS_FAN_OUT_STATE     = 8'hA8;

	localparam int BIT_ALARM_EN     = 1;
	localparam int BIT_TEMP_LATCH   = 7;
	localparam int BIT_MISSING      = 1;
	localparam int BIT_FAULT        = 2;
	localparam int BIT_HOTPLUG_PRIO = 5;
	localparam int BIT_TACH         = 6;
	localparam int BIT_HOTPLUG      = 7;

	localparam logic [7:0] RST_DUTY     = 8'hFF;
	localparam logic [7:0] RST_COOL     = 8'h03;
	localparam logic [7:0] RST_RANGE    = 8'h4F;
	localparam logic [7:0] RST_HIGH     = 8'h50;
	localparam logic [7:0] RST_TURN_ON  = 8'h28;
	localparam logic [7:0] STATUS_LATCH = 8'hC6;
	localparam logic [7:0] SYNC_IDLE    = 8'h0F;
	localparam logic [3:0] DUTY_FULL    = 4'hF;

	localparam int  CLOCK_HZ        = 10_000_000;
	localparam int  SPINUP_MS       = 2000;
	localparam int  SPINUP_CYCLES   = CLOCK_HZ / 1000 * SPINUP_MS;
	localparam int  NCH             = 3;
	localparam int  NFAN            = 2;
endpackage : fpmc_pkg

// ---- test/fpmc_fan_model.sv ----
// fan-side model: plug state, fault and tach lines, duty seen on the open-drain pwm wires
`timescale 1ns/100ps
module fpmc_fan_model (
	input  wire logic       clock,
	input  wire logic [1:0] pwm_oe,
	input  wire logic [1:0] plugged,
	input  wire logic [1:0] stuck,
	input  wire logic [1:0] slow,
	output logic      [1:0] present,
	output logic      [1:0] fault_n,
	output logic      [1:0] tach_fail,
	output logic      [4:0] duty0,
	output logic      [4:0] duty1
);
	logic [1:0]  line;
	logic [14:0] hist0;
	logic [14:0] hist1;
	// pull-up holds the wire high whenever the controller lets go of it
	assign line      = ~pwm_oe;
	assign present   = plugged;
	// an unplugged fan cannot pull its fault line, the pull-up wins
	assign fault_n   = ~(stuck & plugged);
	assign tach_fail = slow & plugged;
	// one full pwm period of history, so the count equals the duty code
	always_ff @(posedge clock) begin
		hist0 <= {hist0[13:0], line[0]};
		hist1 <= {hist1[13:0], line[1]};
	end
	assign duty0 = 5'($countones(hist0));
	assign duty1 = 5'($countones(hist1));
endmodule : fpmc_fan_model

// ---- test/testbench.sv ----
// regression bench: register access, pwm duty, thermal trip, event latches, automatic loop
`timescale 1ns/100ps
module testbench;
	logic        clock;
	logic        rst         = 1'h1;
	logic        wb_cyc_i    = 1'h0;
	logic        wb_stb_i    = 1'h0;
	logic        wb_we_i     = 1'h0;
	logic [7:0]  wb_adr_i    = 8'h00;
	logic [3:0]  wb_sel_i    = 4'h1;
	logic [31:0] wb_dat_i    = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        wb_err_o;
	logic [23:0] temp_i      = 24'h0;
	logic [1:0]  hotplug_req = 2'h0;
	logic [1:0]  plugged     = 2'h3;
	logic [1:0]  stuck       = 2'h0;
	logic [1:0]  slow        = 2'h0;
	logic [1:0]  present;
	logic [1:0]  fault_n;
	logic [1:0]  tach_fail;
	logic [1:0]  pwm_o;
	logic [1:0]  pwm_oe;
	logic        int_n_o;
	logic [4:0]  duty0;
	logic [4:0]  duty1;
	logic [31:0] rd_data;
	int          num_errors   = 0;
	int          total_checks = 0;
	int          cycles       = 0;
	logic [7:0]  ra [7]  = '{8'h48, 8'h4A, 8'h60, 8'h61, 8'h88, 8'h92, 8'hA6};
	logic [7:0]  rv [7]  = '{8'h03, 8'h03, 8'hFF, 8'hFF, 8'h4F, 8'h50, 8'h28};
	logic [7:0]  clr [5] = '{8'hA0, 8'hA1, 8'h40, 8'h41, 8'h42};

	fpmc_fan_mode #(.SPINUP_LEN(60)) dut (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .temp_i(temp_i), .fan_present_i(present),
		.fan_fault_n_i(fault_n), .tach_fail_i(tach_fail), .hotplug_req_i(hotplug_req), .pwm_o(pwm_o),
		.pwm_oe(pwm_oe), .int_n_o(int_n_o));
	fpmc_fan_model fan (.clock(clock), .pwm_oe(pwm_oe), .plugged(plugged), .stuck(stuck), .slow(slow),
		.present(present), .fault_n(fault_n), .tach_fail(tach_fail), .duty0(duty0), .duty1(duty1));

	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	// a hung handshake would otherwise stall the run forever
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// error answers read back as all ones, which no 8-bit register can return
	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i  <= we;
		wb_sel_i <= 4'h1;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		do @(posedge clock); while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
		rd_data = (wb_err_o === 1'h1) ? 32'hFFFFFFFF : wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask : wb

	task automatic rdbit(input logic [7:0] a, input int b, input logic exp, input string what);
		repeat (6) @(posedge clock);
		wb(1'h0, a, 8'h00);
		check(32'(rd_data[b]), 32'(exp), what);
	endtask : rdbit

	task automatic duty(input int f, input logic [4:0] exp, input string what);
		repeat (60) @(posedge clock);
		check(32'(f ? duty1 : duty0), 32'(exp), what);
	endtask : duty

	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'h0;
		foreach (ra[i]) begin
			wb(1'h0, ra[i], 8'h00);
			check(rd_data, {24'h0, rv[i]}, "reset value");
		end
		wb(1'h0, 8'h00, 8'h00);
		check(rd_data, 32'hFFFFFFFF, "unmapped address");
		foreach (clr[i]) wb(1'h1, clr[i], 8'h00);
		repeat (2) @(posedge clock);
		check(32'(int_n_o), 32'h1, "interrupt idle");
		$display("test reset: done");
		foreach (ra[i]) if (i < 2) wb(1'h1, ra[i], 8'h00);
		wb(1'h1, 8'h49, 8'h00);
		for (int c = 0; c < 16; c++) begin
			wb(1'h1, 8'h60, {4'hF, 4'(c)});
			duty(0, 5'(c), "software duty");
		end
		check(32'(pwm_o[0]), 32'h1, "pwm pin high at full code");
		wb(1'h1, 8'h61, 8'h07);
		duty(1, 5'h07, "fan2 software duty");
		$display("test software: done");
		stuck <= 2'h1;
		repeat (6) @(posedge clock);
		check(32'(int_n_o), 32'h0, "interrupt low");
		stuck <= 2'h0;
		rdbit(8'hA0, 2, 1'h1, "fault latch held");
		wb(1'h1, 8'hA0, 8'h00);
		rdbit(8'hA0, 2, 1'h0, "fault latch cleared");
		slow <= 2'h2;
		rdbit(8'hA1, 6, 1'h1, "tach latch");
		slow <= 2'h0;
		plugged <= 2'h2;
		rdbit(8'hA0, 1, 1'h1, "missing latch");
		plugged <= 2'h3;
		rdbit(8'hA0, 7, 1'h1, "hot-plug latch");
		foreach (clr[i]) wb(1'h1, clr[i], 8'h00);
		repeat (2) @(posedge clock);
		check(32'(int_n_o), 32'h1, "interrupt released");
		$display("test latches: done");
		wb(1'h1, 8'h60, 8'hA5);
		wb(1'h1, 8'h92, 8'h46);
		wb(1'h1, 8'hA6, 8'h7F);
		wb(1'h1, 8'h42, 8'h02);
		wb(1'h1, 8'h4A, 8'h01);
		temp_i <= 24'h470000;
		duty(0, 5'h0A, "alarm speed");
		rdbit(8'h42, 7, 1'h1, "temp latch");
		wb(1'h1, 8'h42, 8'h02);
		duty(0, 5'h0A, "trip held while hot");
		hotplug_req <= 2'h1;
		duty(0, 5'h0A, "alarm over hot-plug");
		wb(1'h1, 8'hA0, 8'h20);
		duty(0, 5'h0F, "hot-plug over alarm");
		hotplug_req <= 2'h0;
		wb(1'h1, 8'hA0, 8'h00);
		temp_i <= 24'h200000;
		duty(0, 5'h0A, "trip held after cooling");
		wb(1'h1, 8'h42, 8'h02);
		duty(0, 5'h00, "trip released");
		$display("test trip: done");
		wb(1'h1, 8'h4A, 8'h00);
		wb(1'h1, 8'h42, 8'h00);
		wb(1'h1, 8'h60, 8'h05);
		wb(1'h1, 8'h88, 8'h48);
		wb(1'h1, 8'h48, 8'h03);
		temp_i <= 24'h000020;
		duty(0, 5'h00, "off below turn-on");
		temp_i <= 24'h00002C;
		duty(0, 5'h0F, "spin-up full duty");
		duty(0, 5'h0A, "slope duty");
		temp_i <= 24'h000030;
		duty(0, 5'h0F, "full at top point");
		rdbit(8'hA8, 4, 1'h1, "local channel running");
		temp_i <= 24'h000025;
		duty(0, 5'h05, "minimum inside margin");
		temp_i <= 24'h000023;
		duty(0, 5'h00, "off below margin");
		$display("test auto: done");
		tally_and_finish();
	end
endmodule : testbench
